// ### logic/sad_pkg.sv
package sad_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_MODE       = 8'h00;
    localparam logic [7:0]  OFF_REG_SEL    = 8'h04;
    localparam logic [7:0]  OFF_REG_DATA   = 8'h08;
    localparam logic [7:0]  OFF_LAST_ADDR  = 8'h0C;
    localparam logic [7:0]  OFF_STORE_CNT  = 8'h10;
    localparam logic [31:0] MODE_RESET     = 32'h0000_0000;
    localparam int          REG_SEL_W      = 6;
    // ------------------------------------------------------------
    // Mode register layout
    // ------------------------------------------------------------
    localparam int          MODE_B_BASE    = 8;
    localparam int          BK0_LSB        = 16;
    localparam int          BK1_LSB        = 21;
    localparam logic [1:0]  CIRC_BK0       = 2'h1;
    localparam logic [1:0]  CIRC_BK1       = 2'h2;
    localparam logic [4:0]  CIRC_FIRST     = 5'h04;
    localparam logic [4:0]  CIRC_LAST      = 5'h07;
    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam int          CREG_LSB       = 29;
    localparam int          Z_BIT          = 28;
    localparam int          SRC_LSB        = 23;
    localparam int          BASE_LSB       = 18;
    localparam int          OFFS_LSB       = 13;
    localparam int          AMODE_LSB      = 9;
    localparam int          LONG_LSB       = 8;
    localparam int          Y_BIT          = 7;
    localparam int          OP_LSB         = 4;
    localparam int          S_BIT          = 1;
    localparam logic [2:0]  OP_BYTE        = 3'h3;
    localparam logic [2:0]  OP_HALF        = 3'h5;
    localparam logic [1:0]  FMT_SHORT      = 2'h1;
    localparam logic [1:0]  FMT_LONG       = 2'h3;
    localparam logic [4:0]  LONG_BASE_LOW  = 5'h0E;
    localparam logic [4:0]  LONG_BASE_HIGH = 5'h0F;
    localparam logic [4:0]  ZERO_IDX       = 5'h00;
    localparam logic [4:0]  ONE_IDX        = 5'h01;
    localparam logic [4:0]  TWO_IDX        = 5'h02;
endpackage

// ### logic/sad_agen_if.sv
`timescale 1ns/1ps
interface sad_agen_if;
    logic [31:0] base;
    logic [31:0] offset;
    logic        half;
    logic        sub;
    logic        send_new;
    logic        circ;
    logic [4:0]  blk;
    logic [31:0] new_base;
    logic [31:0] addr;
    modport ctrl (output base, offset, half, sub, send_new, circ, blk,
                  input new_base, addr);
    modport agen (input base, offset, half, sub, send_new, circ, blk,
                  output new_base, addr);
endinterface

// ### logic/sad_regfile.sv
`timescale 1ns/1ps
module sad_regfile #(
    parameter int AW  = 6,
    parameter int W   = 32,
    parameter int NRD = 5
) (
    input  wire logic                    clk,
    input  wire logic [NRD-1:0][AW-1:0]  rd_addr,
    output      logic [NRD-1:0][W-1:0]   rd_data,
    input  wire logic                    we,
    input  wire logic [AW-1:0]           wa,
    input  wire logic [W-1:0]            wd
);
    logic [W-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[wa] <= wd;
        end
    end

    // Registered read ports; a write lands one edge before it is visible
    always_ff @(posedge clk) begin
        for (int i = 0; i < NRD; i++) begin
            rd_data[i] <= mem[rd_addr[i]];
        end
    end
endmodule

// ### logic/sad_agen.sv
`timescale 1ns/1ps
module sad_agen (
    sad_agen_if.agen a
);
    logic [31:0] scaled;
    logic [31:0] sum;
    logic [31:0] mask;

    always_comb begin
        scaled = a.half ? {a.offset[30:0], 1'b0} : a.offset;
        sum    = a.sub ? a.base - scaled : a.base + scaled;
        // Block of 2^(blk+1) bytes; blk of 31 yields a full-width mask
        mask   = ~(32'hFFFF_FFFF << ({1'b0, a.blk} + 6'h01));
        if (a.circ) begin
            a.new_base = (a.base & ~mask) | (sum & mask);
        end else begin
            a.new_base = sum;
        end
        a.addr = a.send_new ? a.new_base : a.base;
    end
endmodule

// ### logic/sad_store_unit.sv
`timescale 1ns/1ps
module sad_store_unit #(
    parameter int IDX_W = 5
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Instruction issue
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr,
    output      logic        instr_ready,
    // Data memory store port
    output      logic        mem_we,
    output      logic [31:0] mem_addr,
    output      logic [31:0] mem_wdata,
    output      logic [3:0]  mem_be,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr
);
    localparam int AW = IDX_W + 1;
    localparam int NRD = 5;
    localparam int P_SRC = 0;
    localparam int P_BASE = 1;
    localparam int P_OFF = 2;
    localparam int P_PRED = 3;
    localparam int P_SW = 4;
    localparam int REG_SEL_LEN = sad_pkg::REG_SEL_W;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Mode bits: [3] modify, [2] register offset, [1] post, [0] add
    function automatic logic mode_legal(input logic [3:0] m);
        return m[3] || !m[1];
    endfunction

    function automatic logic [AW-1:0] reg_addr(input logic f,
                                               input logic [4:0] i);
        return {f, i[IDX_W-1:0]};
    endfunction

    // Only bases 4 to 7 of a file may go circular
    function automatic logic circ_capable(input logic [4:0] i);
        return i >= sad_pkg::CIRC_FIRST && i <= sad_pkg::CIRC_LAST;
    endfunction

    // ------------------------------------------------------------
    // Issue-stage decode
    // ------------------------------------------------------------
    logic [1:0]  fmt;
    logic [2:0]  op;
    logic        is_long;
    logic        is_short;
    logic        legal;
    logic        take;
    logic        y_bit;
    logic        src_file;
    logic [4:0]  base_idx;
    logic [2:0]  creg;
    logic [AW-1:0] pred_addr;
    logic [NRD-1:0][AW-1:0] rd_addr;
    logic [NRD-1:0][31:0]   rd_data;
    // Software window: {file, index}
    logic [REG_SEL_LEN-1:0] reg_sel_q;

    always_comb begin
        // Fields both forms share
        fmt      = instr[3:2];
        op       = instr[sad_pkg::OP_LSB +: 3];
        y_bit    = instr[sad_pkg::Y_BIT];
        src_file = instr[sad_pkg::S_BIT];
        creg     = instr[sad_pkg::CREG_LSB +: 3];
        is_long  = fmt == sad_pkg::FMT_LONG;
        is_short = fmt == sad_pkg::FMT_SHORT;
        legal    = (op == sad_pkg::OP_BYTE || op == sad_pkg::OP_HALF)
                   && (is_long || (is_short && mode_legal(
                       instr[sad_pkg::AMODE_LSB +: 4])))
                   && creg != 3'h7;
        // Long form is tied to the second unit; y only picks 14 or 15
        if (is_long) begin
            base_idx = y_bit ? sad_pkg::LONG_BASE_HIGH
                             : sad_pkg::LONG_BASE_LOW;
        end else begin
            base_idx = instr[sad_pkg::BASE_LSB +: 5];
        end
        // Codes 0 and 7 have no predicate register;
        // they park on A0 and the result is unused
        unique case (creg)
            3'h1:    pred_addr = reg_addr(1'b1, sad_pkg::ZERO_IDX);
            3'h2:    pred_addr = reg_addr(1'b1, sad_pkg::ONE_IDX);
            3'h3:    pred_addr = reg_addr(1'b1, sad_pkg::TWO_IDX);
            3'h4:    pred_addr = reg_addr(1'b0, sad_pkg::ONE_IDX);
            3'h5:    pred_addr = reg_addr(1'b0, sad_pkg::TWO_IDX);
            3'h6:    pred_addr = reg_addr(1'b0, sad_pkg::ZERO_IDX);
            default: pred_addr = reg_addr(1'b0, sad_pkg::ZERO_IDX);
        endcase
        rd_addr[P_SRC]  = reg_addr(src_file, instr[sad_pkg::SRC_LSB +: 5]);
        // Base and offset from the unit's own file
        rd_addr[P_BASE] = reg_addr(is_long | y_bit, base_idx);
        rd_addr[P_OFF]  = reg_addr(y_bit,
                                   instr[sad_pkg::OFFS_LSB +: 5]);
        rd_addr[P_PRED] = pred_addr;
        rd_addr[P_SW]   = reg_sel_q[AW-1:0];
    end

    // ------------------------------------------------------------
    // First execute stage registers
    // ------------------------------------------------------------
    // Fields held for the execute cycle; operand
    // data arrive from the registered read ports
    logic        e1_v_q;
    logic        e1_long_q;
    logic        e1_half_q;
    logic        e1_y_q;
    logic [4:0]  e1_base_idx_q;
    logic [3:0]  e1_mode_q;
    logic [14:0] e1_cst_q;
    logic [2:0]  e1_creg_q;
    logic        e1_z_q;

    // One store in flight at a time so the next one reads the updated base
    assign instr_ready = !e1_v_q;
    // Illegal words are dropped without a trace
    assign take        = instr_valid && instr_ready && legal;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            e1_v_q <= 1'b0;
        end else begin
            e1_v_q <= take;
        end
    end

    always_ff @(posedge clk) begin
        if (take) begin
            // Held only on a take
            e1_long_q     <= is_long;
            e1_half_q     <= op == sad_pkg::OP_HALF;
            e1_y_q        <= y_bit;
            e1_base_idx_q <= base_idx;
            e1_mode_q     <= instr[sad_pkg::AMODE_LSB +: 4];
            e1_cst_q      <= instr[sad_pkg::LONG_LSB +: 15];
            e1_creg_q     <= creg;
            e1_z_q        <= instr[sad_pkg::Z_BIT];
        end
    end

    // ------------------------------------------------------------
    // Register file and address generator
    // ------------------------------------------------------------
    logic          rf_we;
    logic [AW-1:0] rf_wa;
    logic [31:0]   rf_wd;

    // Ports: source, base, offset, predicate, window
    sad_regfile #(
        .AW  (AW),
        .W   (32),
        .NRD (NRD)
    ) u_rf (
        .clk     (clk),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .we      (rf_we),
        .wa      (rf_wa),
        .wd      (rf_wd)
    );

    // Address arithmetic is combinational
    sad_agen_if agen_bus ();

    sad_agen u_agen (
        .a (agen_bus)
    );

    // Circular mode table
    logic [31:0] mode_q;
    logic        cond;
    logic        fire;
    logic        base_wb;
    logic [1:0]  circ_fld;
    logic [4:0]  fld_lsb;

    always_comb begin
        // z flips the test to fire on zero
        if (e1_creg_q == 3'h0) begin
            cond = 1'b1;
        end else begin
            cond = (rd_data[P_PRED] != 32'h0000_0000) ^ e1_z_q;
        end
        fire    = e1_v_q && cond;
        base_wb = fire && !e1_long_q && e1_mode_q[3];
        // Two mode bits per capable base
        fld_lsb = (e1_y_q ? 5'(sad_pkg::MODE_B_BASE) : 5'h00)
                  + {e1_base_idx_q[1:0], 1'b0};
        circ_fld = mode_q[fld_lsb +: 2];
        agen_bus.base = rd_data[P_BASE];
        agen_bus.half = e1_half_q;
        // Long form: plain add, no write-back
        if (e1_long_q) begin
            agen_bus.offset   = {17'h0_0000, e1_cst_q};
            agen_bus.sub      = 1'b0;
            agen_bus.send_new = 1'b1;
            agen_bus.circ     = 1'b0;
        end else begin
            // Register and constant share one field
            if (e1_mode_q[2]) begin
                agen_bus.offset = rd_data[P_OFF];
            end else begin
                agen_bus.offset = {27'h000_0000, e1_cst_q[5 +: 5]};
            end
            agen_bus.sub      = !e1_mode_q[0];
            agen_bus.send_new = !e1_mode_q[1];
            agen_bus.circ     = circ_capable(e1_base_idx_q)
                                && (circ_fld == sad_pkg::CIRC_BK0
                                    || circ_fld == sad_pkg::CIRC_BK1);
        end
        // Block size follows the base's code
        if (circ_fld == sad_pkg::CIRC_BK1) begin
            agen_bus.blk = mode_q[sad_pkg::BK1_LSB +: 5];
        end else begin
            agen_bus.blk = mode_q[sad_pkg::BK0_LSB +: 5];
        end
    end

    // ------------------------------------------------------------
    // Memory store port
    // ------------------------------------------------------------
    // Address, data and enables change together
    logic [31:0] mem_addr_q;
    logic [31:0] mem_wdata_q;
    logic [3:0]  mem_be_q;
    logic        mem_we_q;
    logic [31:0] src;

    // Source follows s, not y
    assign src = rd_data[P_SRC];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_we_q    <= 1'b0;
            mem_addr_q  <= 32'h0000_0000;
            mem_wdata_q <= 32'h0000_0000;
            mem_be_q    <= 4'h0;
        end else begin
            // Data on all lanes; enables pick
            mem_we_q <= fire;
            if (fire) begin
                mem_addr_q <= agen_bus.addr;
                if (e1_half_q) begin
                    mem_wdata_q <= {2{src[15:0]}};
                    mem_be_q    <= agen_bus.addr[1] ? 4'hC : 4'h3;
                end else begin
                    mem_wdata_q <= {4{src[7:0]}};
                    mem_be_q    <= 4'(4'h1 << agen_bus.addr[1:0]);
                end
            end
        end
    end

    assign mem_we    = mem_we_q;
    assign mem_addr  = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
    assign mem_be    = mem_be_q;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Waits only on a write-back clash
    logic        acc;
    logic        wr_hit;
    logic        mapped;
    logic        rf_sw_wr;
    logic [31:0] last_addr_q;
    logic [31:0] store_cnt_q;

    always_comb begin
        // Error is a plain decode of the address
        mapped = paddr == sad_pkg::OFF_MODE
                 || paddr == sad_pkg::OFF_REG_SEL
                 || paddr == sad_pkg::OFF_REG_DATA
                 || paddr == sad_pkg::OFF_LAST_ADDR
                 || paddr == sad_pkg::OFF_STORE_CNT;
        // Base write-back owns the register file port for its one cycle
        pready  = !(base_wb && paddr == sad_pkg::OFF_REG_DATA);
        acc     = psel && penable && pready;
        wr_hit  = acc && pwrite;
        pslverr = !mapped;
        // The window reads a cycle behind the select
        unique case (paddr)
            sad_pkg::OFF_MODE:      prdata = mode_q;
            sad_pkg::OFF_REG_SEL:   prdata = 32'(reg_sel_q);
            sad_pkg::OFF_REG_DATA:  prdata = rd_data[P_SW];
            sad_pkg::OFF_LAST_ADDR: prdata = last_addr_q;
            sad_pkg::OFF_STORE_CNT: prdata = store_cnt_q;
            default:                prdata = 32'h0000_0000;
        endcase
        // One write port: write-back goes first
        rf_sw_wr = wr_hit && paddr == sad_pkg::OFF_REG_DATA;
        rf_we    = base_wb || rf_sw_wr;
        if (base_wb) begin
            rf_wa = reg_addr(e1_y_q, e1_base_idx_q);
            rf_wd = agen_bus.new_base;
        end else begin
            rf_wa = reg_sel_q[AW-1:0];
            rf_wd = pwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= sad_pkg::MODE_RESET;
        end else if (wr_hit && paddr == sad_pkg::OFF_MODE) begin
            // A store in flight sees it next cycle
            mode_q <= pwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_sel_q <= '0;
        end else if (wr_hit && paddr == sad_pkg::OFF_REG_SEL) begin
            // Upper bits are dropped
            reg_sel_q <= pwdata[REG_SEL_LEN-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_addr_q <= 32'h0000_0000;
            store_cnt_q <= 32'h0000_0000;
        end else if (fire) begin
            // Skipped stores stay uncounted
            last_addr_q <= agen_bus.addr;
            store_cnt_q <= store_cnt_q + 32'h0000_0001;
        end
    end
endmodule

// ### bench/sad_store_asserts.sv
`timescale 1ns/1ps
module sad_store_asserts (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        instr_valid,
    input wire logic [31:0] instr,
    input wire logic        instr_ready,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0]  mem_be,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Refused words are consumed without closing the issue slot
    logic [3:0] md;
    logic       legal_st;
    assign md       = instr[sad_pkg::AMODE_LSB +: 4];
    assign legal_st = (instr[sad_pkg::OP_LSB +: 3] == sad_pkg::OP_BYTE
                       || instr[sad_pkg::OP_LSB +: 3] == sad_pkg::OP_HALF)
                      && (instr[3:2] == sad_pkg::FMT_LONG
                          || (instr[3:2] == sad_pkg::FMT_SHORT
                              && (md[3] || !md[1])))
                      && instr[sad_pkg::CREG_LSB +: 3] != 3'h7;
    // ------------------------------------------------------------
    // Store port timing
    // ------------------------------------------------------------
    we_origin_a: assert property (
        mem_we |-> $past(instr_valid && instr_ready, 2))
        else $error("store write without a take two cycles before");
    take_gap_a: assert property (
        instr_valid && instr_ready && legal_st |=> !instr_ready)
        else $error("issue not closed in the cycle after a take");
    ready_back_a: assert property (
        !instr_ready |=> instr_ready)
        else $error("issue closed for more than one cycle");
    we_single_a: assert property (mem_we |=> !mem_we)
        else $error("store write longer than one cycle");
    // ------------------------------------------------------------
    // Lanes and data
    // ------------------------------------------------------------
    lane_match_a: assert property (mem_we |->
        (mem_be == (4'h1 << mem_addr[1:0])) ||
        (mem_be == (4'h3 << mem_addr[1:0]) && !mem_addr[0]))
        else $error("byte enables do not match address");
    byte_rep_a: assert property (
        mem_we && $onehot(mem_be) |-> mem_wdata == {4{mem_wdata[7:0]}})
        else $error("byte data not on all lanes");
    half_rep_a: assert property (
        mem_we && (mem_be == 4'h3 || mem_be == 4'hC)
        |-> mem_wdata == {2{mem_wdata[15:0]}})
        else $error("halfword data not on both halves");
    // Outputs hold between stores so the memory never sees a glitch
    addr_hold_a: assert property (
        !mem_we |-> $stable(mem_addr) && $stable(mem_wdata))
        else $error("store address or data moved between stores");
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("more than one wait state");
    unmapped_a: assert property (psel && penable && paddr > 8'h10
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not flagged");
endmodule

bind sad_store_unit sad_store_asserts u_sad_store_asserts (
    .clk, .sys_rst, .instr_valid, .instr, .instr_ready, .mem_we,
    .mem_addr, .mem_wdata, .mem_be, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);

// ### bench/sad_mem_model.sv
`timescale 1ns/1ps
module sad_mem_model (
    input wire logic        clk,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0]  mem_be
);
    logic [7:0] mem [0:65535];
    // Known fill so an unwanted lane write shows up
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ 8'hA5;
        end
    end
    always @(posedge clk) begin
        if (mem_we === 1'b1) begin
            for (int l = 0; l < 4; l++) begin
                if (mem_be[l]) begin
                    mem[{mem_addr[15:2], l[1:0]}] = mem_wdata[8*l +: 8];
                end
            end
        end
    end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam logic [2:0] OB = sad_pkg::OP_BYTE;
    localparam logic [2:0] OH = sad_pkg::OP_HALF;
    logic        clk;
    logic        sys_rst;
    logic        instr_valid;
    logic [31:0] instr;
    logic        instr_ready;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [3:0]  mem_be;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rdat;
    logic        rerr;
    int          fail_count;
    int          n_compared;
    int          cyc;

    sad_store_unit u_sad_store_unit (.clk, .sys_rst, .instr_valid, .instr,
        .instr_ready, .mem_we, .mem_addr, .mem_wdata, .mem_be, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    sad_mem_model u_sad_mem_model (.clk, .mem_we, .mem_addr, .mem_wdata,
        .mem_be);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Entered just after an edge; returns one edge after release
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        #1;
        while (pready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        rdat = prdata;
        rerr = pslverr;
        @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic f, input logic [4:0] i,
                      input logic [31:0] v);
        apb(1'b1, sad_pkg::OFF_REG_SEL, {26'h0, f, i});
        apb(1'b1, sad_pkg::OFF_REG_DATA, v);
    endtask
    task automatic rd(input logic f, input logic [4:0] i);
        apb(1'b1, sad_pkg::OFF_REG_SEL, {26'h0, f, i});
        apb(1'b0, sad_pkg::OFF_REG_DATA, 32'h0);
    endtask
    // Issue one store and look at the port in the cycle of mem_we
    task automatic st(input logic [31:0] ins, input logic we,
                      input logic [31:0] ad, input logic [3:0] be,
                      input logic [31:0] wd);
        instr_valid <= 1'b1;
        instr       <= ins;
        #1;
        while (instr_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        instr_valid <= 1'b0;
        @(posedge clk);
        #1;
        chk("mem_we", {31'h0, we}, {31'h0, mem_we});
        if (we) begin
            chk("mem_addr", ad, mem_addr);
            chk("mem_be", {28'h0, be}, {28'h0, mem_be});
            chk("mem_wdata", wd, mem_wdata);
        end
        @(posedge clk);
    endtask
    function automatic logic [31:0] sh(input logic [3:0] cz,
        input logic [4:0] src, input logic [4:0] b, input logic [4:0] o,
        input logic [3:0] md, input logic y, input logic [2:0] op,
        input logic s);
        // One y for base and offset; the r bit stays clear
        return {cz, src, b, o, md, 1'b0, y, op, sad_pkg::FMT_SHORT, s,
                1'b0};
    endfunction
    function automatic logic [31:0] lg(input logic [4:0] src,
        input logic [14:0] u, input logic y, input logic [2:0] op,
        input logic s);
        return {4'h0, src, u, y, op, sad_pkg::FMT_LONG, s, 1'b0};
    endfunction
    // ------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        instr_valid = 1'b0;
        instr = 32'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, sad_pkg::OFF_MODE, 32'h0);
        chk("mode_reset", sad_pkg::MODE_RESET, rdat);
        wr(0, 10, 32'h100);
        wr(0, 11, 32'h5);
        wr(1, 2, 32'h9A32_7634);
        wr(0, 1, 32'h1122_3377);
        wr(1, 10, 32'h200);
        wr(1, 11, 32'h1);
        wr(1, 14, 32'h1000);
        wr(1, 15, 32'h0);
        wr(0, 4, 32'h10C);
        wr(0, 8, 32'h10C);
        wr(1, 0, 32'h1);
        st(sh(0, 2, 10, 3, 4'h1, 0, OB, 1), 1, 32'h103, 4'h8, 32'h34343434);
        rd(0, 10);
        chk("base_kept", 32'h100, rdat);
        chk("byte_lane", 32'h34, {24'h0, u_sad_mem_model.mem[16'h0103]});
        chk("next_lane", 32'hA7, {24'h0, u_sad_mem_model.mem[16'h0102]});
        st(sh(0, 1, 10, 11, 4'hD, 0, OB, 0), 1, 32'h105, 4'h2, 32'h77777777);
        st(sh(0, 1, 10, 0, 4'h1, 0, OB, 0), 1, 32'h105, 4'h2, 32'h77777777);
        st(sh(0, 2, 10, 2, 4'hA, 1, OB, 1), 1, 32'h200, 4'h1, 32'h34343434);
        st(sh(0, 2, 10, 11, 4'h5, 1, OH, 1), 1, 32'h200, 4'h3, 32'h76347634);
        st(sh(0, 2, 10, 3, 4'h0, 1, OH, 1), 1, 32'h1F8, 4'h3, 32'h76347634);
        st(sh(0, 2, 10, 11, 4'h5, 1, OB, 1), 1, 32'h1FF, 4'h8, 32'h34343434);
        st(lg(1, 15'h7FFF, 0, OB, 0), 1, 32'h8FFF, 4'h8, 32'h77777777);
        st(lg(2, 15'h0002, 1, OH, 1), 1, 32'h4, 4'h3, 32'h76347634);
        apb(1'b1, sad_pkg::OFF_MODE, 32'h0003_0001);
        st(sh(0, 1, 4, 8, 4'hB, 0, OB, 0), 1, 32'h10C, 4'h1, 32'h77777777);
        rd(0, 4);
        chk("circ_base", 32'h104, rdat);
        st(sh(0, 1, 8, 8, 4'hB, 0, OB, 0), 1, 32'h10C, 4'h1, 32'h77777777);
        rd(0, 8);
        chk("linear_base", 32'h114, rdat);
        st(sh(4'h3, 1, 10, 4, 4'h9, 0, OB, 0), 0, 0, 0, 0);
        rd(0, 10);
        chk("base_skip", 32'h105, rdat);
        st(sh(4'h2, 1, 10, 4, 4'h9, 0, OB, 0), 1, 32'h109, 4'h2, 32'h77777777);
        // Mode code with post but no modify is refused silently
        st(sh(0, 1, 10, 0, 4'h2, 0, OB, 0), 0, 0, 0, 0);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, rerr});
        chk("unmapped_data", 32'h0, rdat);
        apb(1'b1, sad_pkg::OFF_STORE_CNT, 32'h5);
        apb(1'b0, sad_pkg::OFF_STORE_CNT, 32'h0);
        chk("store_count", 32'hC, rdat);
        apb(1'b0, sad_pkg::OFF_LAST_ADDR, 32'h0);
        chk("last_addr", 32'h109, rdat);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, sad_pkg::OFF_MODE, 32'h0);
        chk("mode_rerst", sad_pkg::MODE_RESET, rdat);
        chk("ready_rerst", 32'h1, {31'h0, instr_ready});
        chk("we_rerst", 32'h0, {31'h0, mem_we});
        give_verdict();
    end
endmodule
